// ==== rtl/tgr_timing_recal.sv ====
// module: grouped touch timing events and sensor recalibration control
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module tgr_timing_recal
  import tgr_pkg::*;
#(
  parameter int MS_CYCLES = TGR_MS_CYCLES
)
(
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic      [7:0]             reg_rdata,
  input  wire logic [TGR_NUM_ALL-1:0] touch_raw,
  input  wire logic                   slide_raw,
  input  wire logic [1:0]             slide_speed,
  input  wire logic [TGR_NUM_ALL-1:0] auto_recal_req,
  input  wire logic [7:0]             sensor_enable,
  input  wire logic [6:0]             group_sample_en,
  input  wire logic                   group_repeat_enable,
  input  wire logic                   group_timeout_en,
  output logic [TGR_NUM_ALL-1:0]      touch_valid,
  output logic                        tap_event,
  output logic                        hold_event,
  output logic                        slide_event,
  output logic [TGR_NUM_ALL-1:0]      recal_busy,
  output logic [TGR_NUM_ALL-1:0]      analog_update,
  output logic [TGR_NUM_ALL-1:0]      base_capture
);
  // ==========================================================
  // helpers
  // timing code to milliseconds, linear 35 ms steps
  function automatic logic [TGR_MSW-1:0] code_ms(input logic [3:0] c);
    code_ms = TGR_MSW'(({10'h000, c} + 14'h0001) * TGR_STEP_MS);
  endfunction

  // press timeout decode; code 1101b gives 8906 ms
  function automatic logic [TGR_MSW-1:0] dur_ms(input logic [3:0] c);
    unique case (c)
      4'h0: dur_ms = 14'd560;
      4'h1: dur_ms = 14'd840;
      4'h2: dur_ms = 14'd1120;
      4'h3: dur_ms = 14'd1400;
      4'h4: dur_ms = 14'd1680;
      4'h5: dur_ms = 14'd2240;
      4'h6: dur_ms = 14'd2800;
      4'h7: dur_ms = 14'd3360;
      4'h8: dur_ms = 14'd3920;
      4'h9: dur_ms = 14'd4480;
      4'hA: dur_ms = 14'd5600;
      4'hB: dur_ms = 14'd6720;
      4'hC: dur_ms = 14'd7840;
      4'hD: dur_ms = 14'd8906;
      4'hE: dur_ms = 14'd10080;
      4'hF: dur_ms = 14'd11200;
    endcase
  endfunction

  // ==========================================================
  // input synchronisers
  logic [TGR_NUM_ALL-1:0] touch_s1_q;
  logic [TGR_NUM_ALL-1:0] touch_q;
  logic                   slide_s1_q;
  logic                   slide_q;
  // front-end levels arrive asynchronously; two flops each
  always_ff @(posedge clock)
  begin
    touch_s1_q <= touch_raw;
    touch_q    <= touch_s1_q;
    slide_s1_q <= slide_raw;
    slide_q    <= slide_s1_q;
  end

  // ==========================================================
  // millisecond tick divider
  logic [15:0] div_q;
  wire         ms_tick = (div_q == 16'(MS_CYCLES - 1));
  always_ff @(posedge clock)
  begin
    if (reset || ms_tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  // ==========================================================
  // registers
  logic [7:0] hold_cfg_q;
  logic [7:0] slide_cfg_q;
  logic [7:0] auto_en_q;
  logic [7:0] trig_q;
  logic [7:0] gtrig_q;
  logic [7:0] trig_d;
  logic [7:0] gtrig_d;
  logic [7:0] rdata_q;
  logic [7:0] trig_done;
  logic [7:0] gtrig_done;
  wire wr_hold  = reg_write && (reg_addr == TGR_ADDR_HOLD);
  wire wr_slide = reg_write && (reg_addr == TGR_ADDR_SLIDE);
  wire wr_auto  = reg_write && (reg_addr == TGR_ADDR_AUTOEN);
  wire wr_trig  = reg_write && (reg_addr == TGR_ADDR_TRIG);
  wire wr_gtrig = reg_write && (reg_addr == TGR_ADDR_GTRIG);
  wire [3:0] hold_repeat_interval  = hold_cfg_q[7:TGR_HI_LSB];
  wire [3:0] hold_threshold        = hold_cfg_q[3:0];
  wire [3:0] group_press_timeout   = slide_cfg_q[7:TGR_HI_LSB];
  wire [3:0] slide_repeat_interval = slide_cfg_q[3:0];
  // hardware clears done bits; a software write in the same cycle wins
  assign trig_d  = wr_trig  ? reg_wdata : (trig_q & ~trig_done);
  assign gtrig_d = wr_gtrig ? (reg_wdata & TGR_GTRIG_MASK)
                            : (gtrig_q & ~gtrig_done);
  wire [7:0] rd_mux =
    (reg_addr == TGR_ADDR_HOLD)   ? hold_cfg_q  :
    (reg_addr == TGR_ADDR_SLIDE)  ? slide_cfg_q :
    (reg_addr == TGR_ADDR_AUTOEN) ? auto_en_q   :
    (reg_addr == TGR_ADDR_TRIG)   ? trig_q      :
    (reg_addr == TGR_ADDR_GTRIG)  ? gtrig_q     : 8'h00;
  // register storage and read data flop
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hold_cfg_q  <= TGR_RST_HOLD;
      slide_cfg_q <= TGR_RST_SLIDE;
      auto_en_q   <= TGR_RST_AUTOEN;
      trig_q      <= TGR_RST_TRIG;
      gtrig_q     <= TGR_RST_GTRIG;
      rdata_q     <= 8'h00;
    end
    else
    begin
      if (wr_hold)
        hold_cfg_q <= reg_wdata;
      if (wr_slide)
        slide_cfg_q <= reg_wdata;
      if (wr_auto)
        auto_en_q <= reg_wdata;
      trig_q  <= trig_d;
      gtrig_q <= gtrig_d;
      if (reg_read)
        rdata_q <= rd_mux;
    end
  end
  assign reg_rdata = rdata_q;
  // ==========================================================
  // recalibration request gathering
  logic [TGR_NUM_ALL-1:0] cal_mask_q;
  tgr_cal_state_t         cal_state_q;
  logic [9:0]             cal_ms_q;
  logic                   cal_forced_q;
  logic                   timeout_req;
  // an unsampled input never auto-recalibrates
  wire [TGR_NUM_ALL-1:0] sampled = {group_sample_en & {7{sensor_enable[7]}},
                                    sensor_enable[6:0]};
  // individual bits gate 1..7, group bit gates all grouped
  wire [TGR_NUM_ALL-1:0] auto_gate = {{7{auto_en_q[TGR_GROUP_BIT]}},
                                      auto_en_q[6:0]};
  wire [TGR_NUM_ALL-1:0] auto_want = auto_recal_req & auto_gate & sampled;
  wire [TGR_NUM_ALL-1:0] man_want  = {gtrig_q[6:0] |
                                      {7{trig_q[TGR_GROUP_BIT]}},
                                      trig_q[6:0]};
  wire [TGR_NUM_ALL-1:0] tout_want = {{7{timeout_req}}, 7'h00};
  wire [TGR_NUM_ALL-1:0] want      = auto_want | man_want | tout_want;
  wire cal_hit = |(touch_q & cal_mask_q) && !cal_forced_q;
  wire cal_end = ms_tick && (cal_ms_q == 10'(TGR_DIGITAL_MS - 1));
  wire cal_ok  = (cal_state_q == TGR_CAL_DIGITAL) && cal_end && !cal_hit;
  // successful run clears only the bits it covered
  assign trig_done  = cal_ok ? {&cal_mask_q[13:7], cal_mask_q[6:0]}
                             : 8'h00;
  assign gtrig_done = cal_ok ? {1'b0, cal_mask_q[13:7]} : 8'h00;
  // touches are blocked and base counts invalid while busy
  assign touch_valid = touch_q & ~cal_mask_q;
  assign recal_busy  = cal_mask_q;
  // ==========================================================
  // recalibration sequencer: analog phase then digital capture
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cal_state_q   <= TGR_CAL_IDLE;
      cal_mask_q    <= '0;
      cal_ms_q      <= 10'h000;
      cal_forced_q  <= 1'b0;
      analog_update <= '0;
      base_capture  <= '0;
    end
    else
    begin
      analog_update <= '0;
      base_capture  <= '0;
      unique case (cal_state_q)
        TGR_CAL_IDLE:
          if (|want)
          begin
            cal_mask_q   <= want;
            cal_forced_q <= timeout_req;
            cal_ms_q     <= 10'h000;
            cal_state_q  <= TGR_CAL_ANALOG;
          end
        TGR_CAL_ANALOG:
          if (cal_hit)
            cal_state_q <= TGR_CAL_WAIT;
          else if (ms_tick)
          begin
            if (cal_ms_q == 10'(TGR_ANALOG_MS - 1))
            begin
              analog_update <= cal_mask_q;
              cal_ms_q      <= 10'h000;
              cal_state_q   <= TGR_CAL_DIGITAL;
            end
            else
              cal_ms_q <= cal_ms_q + 10'h001;
          end
        TGR_CAL_DIGITAL:
          if (cal_hit)
            cal_state_q <= TGR_CAL_WAIT;
          else if (cal_end)
          begin
            base_capture <= cal_mask_q;
            cal_mask_q   <= '0;
            cal_forced_q <= 1'b0;
            cal_state_q  <= TGR_CAL_IDLE;
          end
          else if (ms_tick)
            cal_ms_q <= cal_ms_q + 10'h001;
        TGR_CAL_WAIT:
          // retry from the start once every covered sensor lets go
          if (!(|(touch_q & cal_mask_q)))
          begin
            cal_ms_q    <= 10'h000;
            cal_state_q <= TGR_CAL_ANALOG;
          end
      endcase
    end
  end

  // ==========================================================
  // grouped press timing: tap, hold, repeat, timeout
  logic [TGR_MSW-1:0] press_ms_q;
  logic [TGR_MSW-1:0] rep_ms_q;
  logic               held_q;
  logic               pressed_q;
  wire group_touch = |touch_valid[13:7];
  wire hold_now    = ms_tick && group_touch && !held_q &&
                     (press_ms_q == code_ms(hold_threshold));
  wire rep_now     = ms_tick && group_touch && held_q &&
                     group_repeat_enable &&
                     (rep_ms_q == code_ms(hold_repeat_interval) -
                      14'h0001);
  assign timeout_req = group_timeout_en && group_touch &&
                       (press_ms_q >= dur_ms(group_press_timeout));
  // the press counter saturates so a long hold cannot wrap into a tap
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      press_ms_q <= '0;
      rep_ms_q   <= '0;
      held_q     <= 1'b0;
      pressed_q  <= 1'b0;
      tap_event  <= 1'b0;
      hold_event <= 1'b0;
    end
    else
    begin
      pressed_q  <= group_touch;
      tap_event  <= pressed_q && !group_touch && !held_q;
      hold_event <= hold_now || rep_now;
      if (!group_touch)
      begin
        press_ms_q <= '0;
        rep_ms_q   <= '0;
        held_q     <= 1'b0;
      end
      else if (ms_tick)
      begin
        if (press_ms_q != '1)
          press_ms_q <= press_ms_q + 14'h0001;
        if (hold_now)
          held_q <= 1'b1;
        rep_ms_q <= (hold_now || rep_now) ? '0 : rep_ms_q + 14'h0001;
      end
    end
  end

  // ==========================================================
  // slide repeat: separate from the hold timer
  logic [TGR_MSW-1:0] slide_ms_q;
  logic               slide_prev_q;
  // faster slides shorten the base interval, never below 1 ms
  wire [TGR_MSW-1:0] slide_per = code_ms(slide_repeat_interval)
                                 >> slide_speed;
  wire slide_rep = ms_tick && slide_q &&
                   (slide_ms_q + 14'h0001 >= slide_per);
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      slide_ms_q   <= '0;
      slide_prev_q <= 1'b0;
      slide_event  <= 1'b0;
    end
    else
    begin
      slide_prev_q <= slide_q;
      slide_event  <= (slide_q && !slide_prev_q) || slide_rep;
      if (!slide_q || slide_rep)
        slide_ms_q <= '0;
      else if (ms_tick)
        slide_ms_q <= slide_ms_q + 14'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/tgr_pkg.sv ====
// package: register map, field layout, resets and timing for touch timing
package tgr_pkg;
  // ==========================================================
  // register offsets and reset values
  localparam logic [7:0] TGR_ADDR_HOLD    = 8'h23;
  localparam logic [7:0] TGR_ADDR_SLIDE   = 8'h24;
  localparam logic [7:0] TGR_ADDR_AUTOEN  = 8'h25;
  localparam logic [7:0] TGR_ADDR_TRIG    = 8'h26;
  localparam logic [7:0] TGR_ADDR_GTRIG   = 8'h46;
  localparam logic [7:0] TGR_RST_HOLD     = 8'h47;
  localparam logic [7:0] TGR_RST_SLIDE    = 8'hD4;
  localparam logic [7:0] TGR_RST_AUTOEN   = 8'hFF;
  localparam logic [7:0] TGR_RST_TRIG     = 8'h00;
  localparam logic [7:0] TGR_RST_GTRIG    = 8'h00;
  // ==========================================================
  // field positions
  localparam int TGR_HI_LSB     = 4;  // upper nibble low bit
  localparam int TGR_GROUP_BIT  = 7;  // group bit in enable/trigger
  localparam int TGR_NUM_SINGLE = 7;  // individual inputs 1..7
  localparam int TGR_NUM_GROUP  = 7;  // grouped inputs 8..14
  localparam int TGR_NUM_ALL    = 14;
  localparam logic [7:0] TGR_GTRIG_MASK = 8'h7F; // bit 7 unused
  // ==========================================================
  // timing
  localparam int TGR_CLK_NS      = 100;     // 10 MHz clock period
  localparam int TGR_MS_NS       = 1000000; // one millisecond
  localparam int TGR_MS_CYCLES   = TGR_MS_NS / TGR_CLK_NS;
  localparam int TGR_STEP_MS     = 35;      // timing code resolution
  localparam int TGR_RECAL_MS    = 600;     // longest recalibration
  localparam int TGR_ANALOG_MS   = 300;     // analog control update
  localparam int TGR_DIGITAL_MS  = TGR_RECAL_MS - TGR_ANALOG_MS;
  localparam int TGR_MSW         = 14;      // width of ms counters
  // ==========================================================
  // recalibration sequencer states
  typedef enum logic [3:0]
  {
    TGR_CAL_IDLE    = 4'b0001,
    TGR_CAL_ANALOG  = 4'b0010,
    TGR_CAL_DIGITAL = 4'b0100,
    TGR_CAL_WAIT    = 4'b1000
  } tgr_cal_state_t;
endpackage

// ==== verification/tgr_checker.sv ====
// checker: port assertions for grouped timing and recalibration
`timescale 1ns/1ps
`default_nettype none
module tgr_checker
  import tgr_pkg::*;
#(
  parameter int MS_CYCLES = 10
)
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [13:0] touch_raw,
  input wire logic [13:0] touch_valid,
  input wire logic        tap_event,
  input wire logic        hold_event,
  input wire logic [13:0] recal_busy,
  input wire logic [13:0] analog_update,
  input wire logic [13:0] base_capture
);
  // ==========================================================
  // helper state
  logic [3:0] thr_q;
  int         run_q;
  int         len_q;
  int         gap_q;
  wire        grp = |touch_valid[13:7];

  // mirror of the hold threshold, grouped press length, time since analog
  always_ff @(posedge clock)
  begin
    if (reset)
      thr_q <= 4'h7;
    else if (reg_write && reg_addr == TGR_ADDR_HOLD)
      thr_q <= reg_wdata[3:0];
    run_q <= grp ? run_q + 1 : 0;
    gap_q <= |analog_update ? 0 : gap_q + 1;
    if (!grp && run_q != 0)
      len_q <= run_q;
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_gtrig_top: assert property (
    reg_read && reg_addr == TGR_ADDR_GTRIG |=> !reg_rdata[7])
    else $error("unused grouped trigger bit read as one");
  a_touch_blocked: assert property (
    touch_valid == ($past(touch_raw, 2) & ~recal_busy))
    else $error("valid touch is not the synced touch outside recalibration");
  a_analog_busy: assert property (
    (analog_update & ~recal_busy) == 14'h0)
    else $error("analog update on an idle sensor");
  a_capture_busy: assert property (
    |base_capture |-> (base_capture & ~$past(recal_busy)) == 14'h0)
    else $error("base capture without a running recalibration");
  a_busy_release: assert property (
    !$past(reset) |-> ($past(recal_busy) & ~recal_busy & ~base_capture
      & ~$past(base_capture)) == 14'h0)
    else $error("busy dropped without a base capture");
  a_tap_short: assert property (
    tap_event |-> !grp && len_q <= (int'(thr_q) + 1) * 35 * MS_CYCLES
      + MS_CYCLES)
    else $error("tap after a press longer than the threshold");
  a_hold_long: assert property (
    hold_event |-> run_q + 2 * MS_CYCLES >= (int'(thr_q) + 1) * 35
      * MS_CYCLES)
    else $error("hold before the threshold ran out");
  a_capture_gap: assert property (
    |base_capture |-> gap_q >= (TGR_DIGITAL_MS - 2) * MS_CYCLES)
    else $error("base capture too soon after analog update");

  c_tap: cover property (tap_event);
  c_hold: cover property (hold_event);
  c_capture: cover property (|base_capture);
endmodule

bind tgr_timing_recal tgr_checker #(.MS_CYCLES(MS_CYCLES)) tgr_checker_inst (
  .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .touch_raw, .touch_valid, .tap_event, .hold_event, .recal_busy,
  .analog_update,
  .base_capture
);
`default_nettype wire

// ==== verification/tgr_front_model.sv ====
// front end model: electrode touch levels and sampler requests
`timescale 1ns/1ps
`default_nettype none
module tgr_front_model
(
  input  wire logic        clock,
  input  wire logic [13:0] press,
  input  wire logic        slide_on,
  input  wire logic [1:0]  speed,
  input  wire logic [13:0] want_cal,
  output logic      [13:0] touch_raw,
  output logic             slide_raw,
  output logic      [1:0]  slide_speed,
  output logic      [13:0] auto_recal_req
);
  // levels follow the finger a cycle late, like a real sampler
  always_ff @(posedge clock)
  begin
    touch_raw      <= press;
    slide_raw      <= slide_on;
    slide_speed    <= speed;
    auto_recal_req <= want_cal;
  end
endmodule
`default_nettype wire

// ==== verification/tgr_timing_recal_tb.sv ====
// testbench: registers, grouped events and recalibration runs
`timescale 1ns/1ps
`default_nettype none
module tgr_timing_recal_tb;
  import tgr_pkg::*;
  localparam int MS = 10;
  localparam logic [7:0] ADR [6] = '{TGR_ADDR_HOLD, TGR_ADDR_SLIDE,
    TGR_ADDR_AUTOEN, TGR_ADDR_TRIG, TGR_ADDR_GTRIG, 8'h27};
  localparam logic [7:0] RST [6] = '{8'h47, 8'hD4, 8'hFF, 8'h00, 8'h00,
    8'h00};
  logic        clock = 1'b0, reset = 1'b1, reg_write = 1'b0;
  logic        reg_read = 1'b0, slide_on = 1'b0, rd_d = 1'b0;
  logic        group_repeat_enable = 1'b1, group_timeout_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, sensor_enable = 8'hFF;
  logic [6:0]  group_sample_en = 7'h7F;
  logic [1:0]  speed = 2'd2;
  logic [13:0] press = '0, want_cal = '0;
  logic [13:0] touch_raw, auto_recal_req, touch_valid;
  logic [13:0] recal_busy, analog_update, base_capture;
  logic [1:0]  slide_speed;
  logic [7:0]  reg_rdata;
  logic        slide_raw, tap_event, hold_event, slide_event;
  logic [31:0] rnd = 32'hBD6B3734;
  int          err_count = 0, n_compared = 0, c;
  logic [7:0]  rd_q[$], ev_q[$];

  tgr_timing_recal #(.MS_CYCLES(MS)) tgr_timing_recal_inst (.clock, .reset,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .touch_raw,
    .slide_raw, .slide_speed, .auto_recal_req, .sensor_enable,
    .group_sample_en, .group_repeat_enable, .group_timeout_en, .touch_valid,
    .tap_event, .hold_event, .slide_event, .recal_busy, .analog_update,
    .base_capture);
  tgr_front_model tgr_front_model_inst (.clock, .press, .slide_on, .speed,
    .want_cal, .touch_raw, .slide_raw, .slide_speed, .auto_recal_req);

  // ==========================================================
  // helpers
  initial
  begin
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // an idle cycle after each strobe keeps drivers from double assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_read = 1'b1;
    rd_q.push_back(e);
    tick(1);
    reg_read = 1'b0;
    tick(1);
  endtask

  task automatic touch(input logic [13:0] m, input int ms);
    press = m;
    tick(ms * MS);
    press = '0;
    tick(50 * MS);
  endtask

  task automatic wait_cap(input int b);
    c = 0;
    while (base_capture[b] !== 1'b1 && c < 9000)
    begin
      tick(1);
      c++;
    end
  endtask

  // results are matched against the oldest note as they appear
  always @(posedge clock)
  begin
    rd_d <= reg_read && !reset;
    if (rd_d)
      check(reg_rdata, rd_q.pop_front());
    if (tap_event === 1'b1)
      check(8'h01, ev_q.pop_front());
    if (hold_event === 1'b1)
      check(8'h02, ev_q.pop_front());
    if (slide_event === 1'b1)
      check(8'h03, ev_q.pop_front());
  end

  // watchdog: the run needs about 43000 cycles
  initial
  begin
    #6000000;
    err_count++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    tick(8);
    reset = 1'b0;
    tick(1);
    for (int i = 0; i < 6; i++)
      rd(ADR[i], RST[i]);
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      wr(ADR[i], rnd[7:0]);
      rd(ADR[i], rnd[7:0]);
    end
    wr(TGR_ADDR_GTRIG, 8'h80);
    rd(TGR_ADDR_GTRIG, 8'h00);
    // hold after 35 ms, repeat every 70 ms; slide base 175 ms
    wr(TGR_ADDR_HOLD, 8'h10);
    wr(TGR_ADDR_SLIDE, 8'hD4);
    wr(TGR_ADDR_AUTOEN, 8'hFF);
    ev_q.push_back(8'h01);
    touch(14'h0100, 20);
    repeat (3) ev_q.push_back(8'h02);
    touch(14'h0100, 200);
    group_repeat_enable = 1'b0;
    ev_q.push_back(8'h02);
    touch(14'h0200, 200);
    // speed 2 quarters the base interval, so two slide events
    repeat (2) ev_q.push_back(8'h03);
    slide_on = 1'b1;
    tick(60 * MS);
    slide_on = 1'b0;
    tick(10 * MS);
    check(8'(ev_q.size()), 8'h00);
    wr(TGR_ADDR_TRIG, 8'h01);
    rd(TGR_ADDR_TRIG, 8'h01);
    wait_cap(0);
    check(8'(c > 5950 && c < 6050), 8'h01);
    rd(TGR_ADDR_TRIG, 8'h00);
    // a touch mid-run aborts; the bit stays and the run restarts
    wr(TGR_ADDR_GTRIG, 8'h01);
    tick(100 * MS);
    touch(14'h0080, 10);
    rd(TGR_ADDR_GTRIG, 8'h01);
    wait_cap(7);
    check(8'(c > 5000 && c < 9000), 8'h01);
    rd(TGR_ADDR_GTRIG, 8'h00);
    wr(TGR_ADDR_TRIG, 8'h80);
    wait_cap(13);
    check({1'b0, base_capture[13:7]}, 8'h7F);
    rd(TGR_ADDR_TRIG, 8'h00);
    // sampler requests count only where sampled and auto enabled
    sensor_enable = 8'hFD;
    want_cal = 14'h0002;
    tick(20);
    check(8'(|recal_busy), 8'h00);
    wr(TGR_ADDR_AUTOEN, 8'h7D);
    want_cal = 14'h3F82;
    sensor_enable = 8'hFF;
    tick(20);
    check(8'(|recal_busy), 8'h00);
    wr(TGR_ADDR_AUTOEN, 8'hFF);
    tick(20);
    check({recal_busy[13:7], recal_busy[1]}, 8'hFF);
    want_cal = '0;
    wait_cap(1);
    check(8'(c < 9000), 8'h01);
    // shortest press timeout: 560 ms of grouped press forces a run
    wr(TGR_ADDR_SLIDE, 8'h04);
    group_timeout_en = 1'b1;
    ev_q.push_back(8'h02);
    press = 14'h0100;
    tick(555 * MS);
    check(8'(|recal_busy), 8'h00);
    tick(10 * MS);
    check({1'b0, recal_busy[13:7]}, 8'h7F);
    press = '0;
    wait_cap(8);
    check(8'(c < 9000), 8'h01);
    check(8'(ev_q.size()), 8'h00);
    group_timeout_en = 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
